// ===== design/acrp_consts.svh
// acrp_consts: offsets, timing figures and reset values for the readout port
// assumes: included by the design files; the clock runs at 125 MHz
`ifndef ACRP_CONSTS_SVH
`define ACRP_CONSTS_SVH

`define ACRP_CLK_MHZ        125
`define ACRP_RES_W          16

// conversion and acquisition times in ns, least times rounded up to cycles
`define ACRP_CONV_TIME_NS   1600
`define ACRP_ACQ_TIME_NS    400
`define ACRP_CONV_CYC       ((`ACRP_CONV_TIME_NS * `ACRP_CLK_MHZ + 999) / 1000)
`define ACRP_ACQ_CYC        ((`ACRP_ACQ_TIME_NS * `ACRP_CLK_MHZ + 999) / 1000)

// width of the incomplete-read pulse
`define ACRP_ERR_PULSE_NS   40
`define ACRP_ERR_CYC        ((`ACRP_ERR_PULSE_NS * `ACRP_CLK_MHZ + 999) / 1000)

// half period of the internally made serial clock
`define ACRP_SCLK_HALF_NS   32
`define ACRP_SCLK_HALF_CYC  ((`ACRP_SCLK_HALF_NS * `ACRP_CLK_MHZ + 999) / 1000)

// pin synchroniser layout and reset value (strobes idle high)
`define ACRP_SYNC_W         12
`define ACRP_SYNC_RST       12'h4C0

// bit positions of the shared pins on the parallel bus
`define ACRP_BIT_SDO        8
`define ACRP_BIT_SCLK       9
`define ACRP_BIT_TEN        10
`define ACRP_BIT_ELEVEN     11

`endif

// ===== design/acrp_pkg.sv
// acrp_pkg: state types of the conversion control and readout port
// assumes: referenced by full name from the design files, never imported
package acrp_pkg;

   typedef enum logic [1:0] {ACRP_ACQ, ACRP_READY, ACRP_CONV, ACRP_DOWN} acrp_conv_e;

   typedef enum logic {ACRP_SI_IDLE, ACRP_SI_SHIFT} acrp_ser_e;

endpackage

// ===== design/acrp_link_shift.sv
// acrp_link_shift: serial shifter clocked by the host-made serial clock
// assumes: cs_n is driven by the host in step with its own clock; word is copied
// on the first edge, so the converter side may change it while a read is running
`timescale 1ns/1ps

module acrp_link_shift (
   input  wire logic        link_clk,
   input  wire logic        cs_n,
   input  wire logic [15:0] word,
   output logic             sdo,
   output logic             active
);

   logic [4:0]  cnt_reg;
   logic [4:0]  cnt_next;
   logic [15:0] sh_reg;
   logic [15:0] sh_next;
   logic        active_reg;
   logic        active_next;

   // the clock may stop between frames, so the frame select is what resets
   always_comb begin
      cnt_next = cnt_reg;
      sh_next  = sh_reg;
      if (cs_n) begin
         cnt_next = 5'h00;
      end else if (cnt_reg == 5'h00) begin
         sh_next  = {word[14:0], 1'b0};
         cnt_next = 5'h01;
      end else if (cnt_reg != 5'h10) begin
         sh_next  = {sh_reg[14:0], 1'b0};
         cnt_next = cnt_reg + 5'h01;
      end
      active_next = (cnt_next != 5'h00) && (cnt_next != 5'h10);
   end

   // link_clk already carries the edge inversion, so this edge is the update edge
   always_ff @(posedge link_clk) begin
      cnt_reg    <= cnt_next;
      sh_reg     <= sh_next;
      active_reg <= active_next;
   end

   // before the first edge the msb is shown straight from the held word
   assign sdo    = (cnt_reg == 5'h00) ? word[15] : sh_reg[15];
   assign active = active_reg;

endmodule

// ===== design/acrp_top.sv
// acrp_top: conversion control and result readout port of a 16-bit sampling converter
// assumes: clk at 125 MHz, nrst synchronous active low, all pins asynchronous to clk
// except ext_sclk and cs_n, which the host drives in step with each other
//
// How it works
// - in serial mode the clock pin is an input or an output per clock source
// - the clock inversion input picks the edge on which serial data changes
// - in parallel mode the sync and error pins carry result bits 10 and 11
// - serial mode drives a frame sync meant for the internal clock
// - low sync polarity: sync high while serial data is valid
// - high sync polarity: sync low while serial data is valid
// - serial mode with external clock turns the error pin into a read error flag
// - an external-clock read still running when a conversion ends keeps shifting out the old result and the flag pulses
// - result bits 12 to 15 are bus outputs in every mode
// - busy rises at conversion start and falls once the result is latched
// - in parallel mode the output bus is enabled only while select and read strobe are both low
// - chip select gates the external serial clock
// - the reset pin resets the block and aborts any conversion
// - power down lets a running conversion finish, then blocks new ones
// - a falling start edge puts the sampler in hold and starts a conversion
// - low-power mode starts at acquisition end if start is still low
// - external clock: data changes on one edge, valid on the opposite one
// - serial data leaves the shift register msb first
`timescale 1ns/1ps
`include "acrp_consts.svh"

module acrp_top #(
   parameter int CONV_CYC  = `ACRP_CONV_CYC,
   parameter int ACQ_CYC   = `ACRP_ACQ_CYC,
   parameter int ERR_CYC   = `ACRP_ERR_CYC,
   parameter int SCLK_HALF = `ACRP_SCLK_HALF_CYC
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        ext_sclk,
   input  wire logic        reset_in,
   input  wire logic        power_down_in,
   input  wire logic        start_convert_n,
   input  wire logic        low_power_sel,
   input  wire logic        fast_mode_sel,
   input  wire logic        interface_select,
   input  wire logic        clock_source_select,
   input  wire logic        clock_edge_invert,
   input  wire logic        frame_sync_polarity,
   input  wire logic        cs_n,
   input  wire logic        rd_n,
   input  wire logic [15:0] sar_code,
   output logic             busy,
   output logic             hold,
   output logic             low_power_out,
   output logic [7:0]       data_lo,
   output logic             lo_oe_n,
   output logic             serial_result_out,
   output logic             sdo_oe_n,
   output logic             sclk_out,
   output logic             sclk_oe_n,
   output logic             bus_bit_ten,
   output logic             bus_bit_eleven,
   output logic             mid_oe_n,
   output logic [3:0]       data_hi,
   output logic             hi_oe_n
);

   // pin synchronisers
   logic [`ACRP_SYNC_W-1:0] pin_raw;
   logic [`ACRP_SYNC_W-1:0] sync_a_reg;
   logic [`ACRP_SYNC_W-1:0] sync_b_reg;
   logic                    start_last_reg;
   logic                    rst_s;
   logic                    pd_s;
   logic                    ser_s;
   logic                    ext_s;
   logic                    inv_s;
   logic                    pol_s;
   logic                    cs_n_s;
   logic                    rd_n_s;
   logic                    lp_s;
   logic                    fast_s;
   logic                    start_n_s;
   logic                    link_act_s;
   logic                    start_fall;
   logic                    impulse;
   logic                    rd_en;

   // conversion control
   acrp_pkg::acrp_conv_e    conv_reg;
   acrp_pkg::acrp_conv_e    conv_next;
   logic [8:0]              cnt_reg;
   logic [8:0]              cnt_next;
   logic                    busy_reg;
   logic                    busy_next;
   logic                    hold_reg;
   logic                    hold_next;
   logic                    pdn_reg;
   logic [15:0]             result_reg;
   logic [15:0]             result_next;
   logic                    go;
   logic                    done;

   // internal-clock serial reader and error flag
   acrp_pkg::acrp_ser_e     si_reg;
   acrp_pkg::acrp_ser_e     si_next;
   logic [15:0]             si_sh_reg;
   logic [15:0]             si_sh_next;
   logic [3:0]              si_bits_reg;
   logic [3:0]              si_bits_next;
   logic [3:0]              si_div_reg;
   logic [3:0]              si_div_next;
   logic                    si_clk_reg;
   logic                    si_clk_next;
   logic                    si_go;
   logic                    unread_reg;
   logic                    unread_next;
   logic [3:0]              err_reg;
   logic [3:0]              err_next;

   // pin output registers
   logic [7:0]              lo_reg;
   logic [7:0]              lo_next;
   logic [3:0]              hi_reg;
   logic [3:0]              hi_next;
   logic                    b8_reg;
   logic                    b8_next;
   logic                    b9_reg;
   logic                    b9_next;
   logic                    b10_reg;
   logic                    b10_next;
   logic                    b11_reg;
   logic                    b11_next;

   // link side
   logic                    link_clk;
   logic                    link_sdo;
   logic                    link_active;

   assign pin_raw = {link_active, start_convert_n, fast_mode_sel, low_power_sel, rd_n, cs_n,
                     frame_sync_polarity, clock_edge_invert, clock_source_select,
                     interface_select, power_down_in, reset_in};
   assign {link_act_s, start_n_s, fast_s, lp_s, rd_n_s, cs_n_s,
           pol_s, inv_s, ext_s, ser_s, pd_s, rst_s} = sync_b_reg;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         sync_a_reg     <= `ACRP_SYNC_RST;
         sync_b_reg     <= `ACRP_SYNC_RST;
         start_last_reg <= 1'b1;
      end else begin
         sync_a_reg     <= pin_raw;
         sync_b_reg     <= sync_a_reg;
         start_last_reg <= start_n_s;
      end
   end

   assign start_fall = start_last_reg && !start_n_s;
   assign impulse    = lp_s && !fast_s;
   assign rd_en      = !cs_n_s && !rd_n_s;

   always_comb begin
      conv_next   = conv_reg;
      cnt_next    = cnt_reg;
      busy_next   = busy_reg;
      hold_next   = hold_reg;
      result_next = result_reg;
      go          = 1'b0;
      done        = 1'b0;
      case (conv_reg)
         acrp_pkg::ACRP_ACQ: begin
            if (cnt_reg != 9'h000) begin
               cnt_next = cnt_reg - 9'h001;
               go       = start_fall && !impulse && !pd_s;
            end else if (pd_s) begin
               conv_next = acrp_pkg::ACRP_DOWN;
            end else if (impulse && !start_n_s) begin
               go = 1'b1;
            end else begin
               conv_next = acrp_pkg::ACRP_READY;
            end
         end
         acrp_pkg::ACRP_READY: begin
            if (pd_s) begin
               conv_next = acrp_pkg::ACRP_DOWN;
            end else begin
               go = start_fall;
            end
         end
         acrp_pkg::ACRP_CONV: begin
            if (cnt_reg == 9'h000) begin
               result_next = sar_code;
               busy_next   = 1'b0;
               hold_next   = 1'b0;
               done        = 1'b1;
               cnt_next    = 9'(ACQ_CYC - 1);
               conv_next   = pd_s ? acrp_pkg::ACRP_DOWN : acrp_pkg::ACRP_ACQ;
            end else begin
               cnt_next = cnt_reg - 9'h001;
            end
         end
         acrp_pkg::ACRP_DOWN: begin
            if (!pd_s) begin
               conv_next = acrp_pkg::ACRP_ACQ;
               cnt_next  = 9'(ACQ_CYC - 1);
            end
         end
         default: begin
            conv_next = acrp_pkg::ACRP_ACQ;
         end
      endcase
      if (go) begin
         conv_next = acrp_pkg::ACRP_CONV;
         cnt_next  = 9'(CONV_CYC - 1);
         busy_next = 1'b1;
         hold_next = 1'b1;
      end
   end

   // the reset pin aborts a conversion exactly like the system reset
   always_ff @(posedge clk) begin
      if (!nrst || rst_s) begin
         conv_reg   <= acrp_pkg::ACRP_ACQ;
         cnt_reg    <= 9'(ACQ_CYC - 1);
         busy_reg   <= 1'b0;
         hold_reg   <= 1'b0;
         pdn_reg    <= 1'b0;
         result_reg <= 16'h0000;
      end else begin
         conv_reg   <= conv_next;
         cnt_reg    <= cnt_next;
         busy_reg   <= busy_next;
         hold_reg   <= hold_next;
         pdn_reg    <= (conv_next == acrp_pkg::ACRP_DOWN);
         result_reg <= result_next;
      end
   end

   assign si_go = (si_reg == acrp_pkg::ACRP_SI_IDLE) && ser_s && !ext_s && rd_en && unread_reg;

   always_comb begin
      si_next      = si_reg;
      si_sh_next   = si_sh_reg;
      si_bits_next = si_bits_reg;
      si_div_next  = si_div_reg;
      si_clk_next  = si_clk_reg;
      unread_next  = unread_reg;
      err_next     = err_reg;
      if (si_go) begin
         unread_next = 1'b0;
      end
      // a result landing as a read starts is kept for the next read
      if (done) begin
         unread_next = 1'b1;
      end
      case (si_reg)
         acrp_pkg::ACRP_SI_IDLE: begin
            if (si_go) begin
               si_next      = acrp_pkg::ACRP_SI_SHIFT;
               si_sh_next   = result_reg;
               si_bits_next = 4'h0;
               si_div_next  = 4'(SCLK_HALF - 1);
               si_clk_next  = 1'b0;
            end
         end
         acrp_pkg::ACRP_SI_SHIFT: begin
            if (si_div_reg != 4'h0) begin
               si_div_next = si_div_reg - 4'h1;
            end else begin
               si_div_next = 4'(SCLK_HALF - 1);
               si_clk_next = !si_clk_reg;
               if (si_clk_reg) begin
                  si_sh_next = {si_sh_reg[14:0], 1'b0};
                  if (si_bits_reg == 4'hF) begin
                     si_next = acrp_pkg::ACRP_SI_IDLE;
                  end else begin
                     si_bits_next = si_bits_reg + 4'h1;
                  end
               end
            end
         end
         default: begin
            si_next = acrp_pkg::ACRP_SI_IDLE;
         end
      endcase
      if (err_reg != 4'h0) begin
         err_next = err_reg - 4'h1;
      end
      if (done && ser_s && ext_s && link_act_s) begin
         err_next = 4'(ERR_CYC);
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst || rst_s) begin
         si_reg      <= acrp_pkg::ACRP_SI_IDLE;
         si_sh_reg   <= 16'h0000;
         si_bits_reg <= 4'h0;
         si_div_reg  <= 4'h0;
         si_clk_reg  <= 1'b0;
         unread_reg  <= 1'b0;
         err_reg     <= 4'h0;
      end else begin
         si_reg      <= si_next;
         si_sh_reg   <= si_sh_next;
         si_bits_reg <= si_bits_next;
         si_div_reg  <= si_div_next;
         si_clk_reg  <= si_clk_next;
         unread_reg  <= unread_next;
         err_reg     <= err_next;
      end
   end

   always_comb begin
      lo_next  = result_reg[7:0];
      hi_next  = result_reg[15:12];
      b8_next  = ser_s ? si_sh_reg[15] : result_reg[`ACRP_BIT_SDO];
      b9_next  = ser_s ? (si_clk_reg ^ inv_s) : result_reg[`ACRP_BIT_SCLK];
      // sync idles at the polarity level, so it never pulses in external mode
      b10_next = ser_s ? ((si_reg == acrp_pkg::ACRP_SI_SHIFT) ^ pol_s)
                       : result_reg[`ACRP_BIT_TEN];
      b11_next = ser_s ? (ext_s && (err_reg != 4'h0))
                       : result_reg[`ACRP_BIT_ELEVEN];
   end

   always_ff @(posedge clk) begin
      if (!nrst || rst_s) begin
         lo_reg  <= 8'h00;
         hi_reg  <= 4'h0;
         b8_reg  <= 1'b0;
         b9_reg  <= 1'b0;
         b10_reg <= 1'b0;
         b11_reg <= 1'b0;
      end else begin
         lo_reg  <= lo_next;
         hi_reg  <= hi_next;
         b8_reg  <= b8_next;
         b9_reg  <= b9_next;
         b10_reg <= b10_next;
         b11_reg <= b11_next;
      end
   end

   // inversion is a static strap; flipping it mid-read would glitch the link clock
   assign link_clk = ext_sclk ^ clock_edge_invert;

   acrp_link_shift u_link (
      .link_clk (link_clk),
      .cs_n     (cs_n),
      .word     (result_reg),
      .sdo      (link_sdo),
      .active   (link_active)
   );

   assign busy              = busy_reg;
   assign hold              = hold_reg;
   assign low_power_out     = pdn_reg;
   assign data_lo           = lo_reg;
   assign data_hi           = hi_reg;
   assign serial_result_out = (ser_s && ext_s) ? link_sdo : b8_reg;
   assign sclk_out          = b9_reg;
   assign bus_bit_ten       = b10_reg;
   assign bus_bit_eleven    = b11_reg;
   assign lo_oe_n           = !(rd_en && !ser_s);
   assign hi_oe_n           = !rd_en;
   assign sdo_oe_n          = !rd_en;
   assign sclk_oe_n         = ser_s ? ext_s : !rd_en;
   assign mid_oe_n          = ser_s ? 1'b0 : !rd_en;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst || rst_s);

   property p_start_hold;
      conv_reg == acrp_pkg::ACRP_READY && start_fall && !pd_s |=> busy && hold;
   endproperty
   a_start_hold: assert property (p_start_hold) else $error("start edge did not begin conversion");

   property p_busy_latch;
      $fell(busy) |-> result_reg == $past(sar_code) && !hold;
   endproperty
   a_busy_latch: assert property (p_busy_latch) else $error("busy fell without latching");

   property p_busy_min;
      $rose(busy) |-> busy [*8];
   endproperty
   a_busy_min: assert property (p_busy_min) else $error("busy dropped early");

   property p_reset_abort;
      @(posedge clk) disable iff (!nrst) rst_s |=> !busy && conv_reg == acrp_pkg::ACRP_ACQ;
   endproperty
   a_reset_abort: assert property (p_reset_abort) else $error("reset did not abort");

   property p_pd_block;
      conv_reg == acrp_pkg::ACRP_READY && pd_s |=> conv_reg == acrp_pkg::ACRP_DOWN && !busy;
   endproperty
   a_pd_block: assert property (p_pd_block) else $error("power down did not block");

   property p_sync_high;
      ser_s && !pol_s && si_reg == acrp_pkg::ACRP_SI_SHIFT && $stable(pol_s) |=> bus_bit_ten;
   endproperty
   a_sync_high: assert property (p_sync_high) else $error("sync not high in frame");

   property p_sync_low;
      ser_s && pol_s && si_reg == acrp_pkg::ACRP_SI_SHIFT && $stable(pol_s) |=> !bus_bit_ten;
   endproperty
   a_sync_low: assert property (p_sync_low) else $error("sync not low in frame");

   property p_rd_error;
      done && ser_s && ext_s && link_act_s |-> ##2 bus_bit_eleven [*4];
   endproperty
   a_rd_error: assert property (p_rd_error) else $error("read error pulse missing");

   property p_par_bits;
      !ser_s |=> bus_bit_ten == $past(result_reg[10]) && bus_bit_eleven == $past(result_reg[11]);
   endproperty
   a_par_bits: assert property (p_par_bits) else $error("parallel bits 10 11 wrong");

   property p_oe_gate;
      cs_n_s || rd_n_s |-> lo_oe_n && hi_oe_n && sdo_oe_n;
   endproperty
   a_oe_gate: assert property (p_oe_gate) else $error("bus enabled while not selected");

   property p_msb_first;
      si_go && $stable(ext_s) |-> ##2 serial_result_out == $past(result_reg[15], 2);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("serial read not msb first");

   c_conversion: cover property ($fell(busy));
   c_int_read:   cover property (si_reg == acrp_pkg::ACRP_SI_SHIFT ##1 si_reg == acrp_pkg::ACRP_SI_IDLE);
   c_rd_error:   cover property ($rose(bus_bit_eleven) && ser_s && ext_s);
   c_power_down: cover property ($rose(low_power_out));

endmodule

// ===== testbench/acrp_host_model.sv
// acrp_host_model: host side of the serial port, supplying the external clock
// assumes: the bench holds cs_n and rd_n; the clock runs inside frames and for single edges between them
`timescale 1ns/1ps

module acrp_host_model (
   output logic      ext_sclk,
   input  wire logic sdo
);
   // the clock rests low between frames, so no stray edge reaches the shifter
   initial ext_sclk = 1'b0;

   // each bit is taken in the low phase, just ahead of the rising edge; the next bit
   // moves out on that edge, or on the falling one when inverted; period is 32 ns
   task automatic run(input int n, output logic [15:0] w);
      w = 16'h0000;
      #7;
      for (int i = 0; i < n; i++) begin
         #16;
         w = {w[14:0], sdo};
         ext_sclk = 1'b1;
         #16;
         ext_sclk = 1'b0;
      end
   endtask
endmodule

// ===== testbench/adc_conversion_and_readout_port_bench.sv
// adc_conversion_and_readout_port_bench: self-checking bench of the readout port
// assumes: short conversion and acquisition counts; host model drives ext_sclk
`timescale 1ns/1ps

module adc_conversion_and_readout_port_bench;
   localparam int CONV = 10;
   localparam int ACQ  = 4;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        reset_in = 1'b0;
   logic        pd = 1'b0;
   logic        start_n = 1'b1;
   logic        ser = 1'b0;
   logic        ext = 1'b0;
   logic        pol = 1'b0;
   logic        lp = 1'b0;
   logic        inv = 1'b0;
   logic        cs_n = 1'b1;
   logic        rd_n = 1'b1;
   logic [15:0] code = 16'hA5C3;
   wire         ext_sclk;
   logic        busy, hold, lp_out, sdo, sdo_oe_n, sclk_out, sclk_oe_n;
   logic        ten, eleven, lo_oe_n, mid_oe_n, hi_oe_n;
   logic [7:0]  data_lo;
   logic [3:0]  data_hi;
   logic [15:0] w;
   int          n;
   int          err_total = 0;
   int          samples_checked = 0;

   always #4 clk = ~clk;

   acrp_top #(.CONV_CYC(CONV), .ACQ_CYC(ACQ)) dut (
      .clk(clk), .nrst(nrst), .ext_sclk(ext_sclk), .reset_in(reset_in),
      .power_down_in(pd), .start_convert_n(start_n), .low_power_sel(lp),
      .fast_mode_sel(1'b0), .interface_select(ser), .clock_source_select(ext),
      .clock_edge_invert(inv), .frame_sync_polarity(pol), .cs_n(cs_n), .rd_n(rd_n),
      .sar_code(code), .busy(busy), .hold(hold), .low_power_out(lp_out),
      .data_lo(data_lo), .lo_oe_n(lo_oe_n), .serial_result_out(sdo),
      .sdo_oe_n(sdo_oe_n), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
      .bus_bit_ten(ten), .bus_bit_eleven(eleven), .mid_oe_n(mid_oe_n),
      .data_hi(data_hi), .hi_oe_n(hi_oe_n));

   acrp_host_model host (.ext_sclk(ext_sclk), .sdo(sdo));

   task automatic end_sim();
      $display("checks %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return busy;
         1: return ten;
         default: return eleven;
      endcase
   endfunction

   // bounded wait; sees values from before the edge, so no race with the design
   task automatic wait_lvl(input int s, input logic lvl);
      for (int i = 0; i < 600; i++) begin
         @(posedge clk);
         if (pick(s) === lvl)
            return;
      end
      err_total++;
      $display("ERROR wait on signal %0d never reached %b", s, lvl);
      end_sim();
   endtask

   task automatic convert();
      @(posedge clk) start_n <= 1'b0;
      repeat (3) @(posedge clk);
      start_n <= 1'b1;
      wait_lvl(0, 1'b1);
      chk("hold", 16'h0001, {15'h0000, hold});
      n = 1;
      for (int i = 0; i < 600; i++) begin
         @(posedge clk);
         if (busy === 1'b0)
            break;
         n++;
      end
      chk("busy_len", CONV[15:0], n[15:0]);
      if (n > 600)
         end_sim();
      repeat (2) @(posedge clk);
   endtask

   task automatic rd(input logic on);
      @(posedge clk);
      cs_n <= ~on;
      rd_n <= ~on;
      repeat (4) @(posedge clk);
   endtask

   initial begin
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      chk("busy_rst", 16'h0000, {15'h0000, busy});
      chk("flags_rst", 16'h0000, {14'h0000, ten, eleven});
      repeat (ACQ + 4) @(posedge clk);
      // parallel read of a full word
      convert();
      rd(1'b1);
      chk("par_word", code, {data_hi, eleven, ten, sclk_out, sdo, data_lo});
      chk("par_oe", 16'h0000, {11'h000, lo_oe_n, sdo_oe_n, sclk_oe_n, mid_oe_n, hi_oe_n});
      rd(1'b0);
      chk("par_off", 16'h001F, {11'h000, lo_oe_n, sdo_oe_n, sclk_oe_n, mid_oe_n, hi_oe_n});
      // internal clock reads, both sync polarities
      for (int p = 0; p < 2; p++) begin
         @(posedge clk);
         ser <= 1'b1;
         pol <= p[0];
         code <= 16'h3C5A ^ {16{p[0]}};
         convert();
         rd(1'b0);
         rd_n <= 1'b0;
         cs_n <= 1'b0;
         wait_lvl(1, ~pol);
         w = 16'h0000;
         n = 0;
         for (int i = 0; i < 400 && n < 16; i++) begin
            @(posedge clk);
            if (sclk_out === 1'b1 && ten === ~pol) begin
               w = {w[14:0], sdo};
               n++;
               while (sclk_out === 1'b1 && i < 400) begin
                  @(posedge clk);
                  i++;
               end
            end
         end
         chk("int_word", code, w);
         chk("int_sclk_oe", 16'h0000, {15'h0000, sclk_oe_n});
         wait_lvl(1, pol);
         rd(1'b0);
      end
      // external clock reads on both clock edges, then an aborted read
      for (int v = 0; v < 2; v++) begin
         @(posedge clk);
         ext <= 1'b1;
         pol <= 1'b0;
         inv <= v[0];
         code <= 16'hC3A5 ^ {16{v[0]}};
         convert();
         host.run(1, w);
         rd(1'b1);
         host.run(16, w);
         chk("ext_word", code, w);
         chk("ext_sclk_oe", 16'h0001, {15'h0000, sclk_oe_n});
         chk("ext_sync", 16'h0000, {15'h0000, ten});
         chk("ext_noerr", 16'h0000, {15'h0000, eleven});
         rd(1'b0);
      end
      host.run(1, w);
      rd(1'b1);
      host.run(5, w);
      code <= 16'h1234;
      convert();
      wait_lvl(2, 1'b1);
      wait_lvl(2, 1'b0);
      rd(1'b0);
      host.run(1, w);
      // low-power mode: start held low restarts at acquisition end
      @(posedge clk);
      lp <= 1'b1;
      start_n <= 1'b0;
      wait_lvl(0, 1'b1);
      wait_lvl(0, 1'b0);
      wait_lvl(0, 1'b1);
      chk("lp_restart", 16'h0001, {15'h0000, hold});
      start_n <= 1'b1;
      wait_lvl(0, 1'b0);
      lp <= 1'b0;
      repeat (ACQ + 4) @(posedge clk);
      // power down, then reset abort
      @(posedge clk);
      ser <= 1'b0;
      pd <= 1'b1;
      repeat (6) @(posedge clk);
      chk("low_power", 16'h0001, {15'h0000, lp_out});
      start_n <= 1'b0;
      repeat (10) @(posedge clk);
      chk("pd_busy", 16'h0000, {15'h0000, busy});
      start_n <= 1'b1;
      pd <= 1'b0;
      repeat (ACQ + 8) @(posedge clk);
      start_n <= 1'b0;
      wait_lvl(0, 1'b1);
      start_n <= 1'b1;
      reset_in <= 1'b1;
      repeat (5) @(posedge clk);
      chk("reset_busy", 16'h0000, {15'h0000, busy});
      reset_in <= 1'b0;
      repeat (ACQ + 8) @(posedge clk);
      end_sim();
   end
endmodule
